// ---- hdl/cbs_pkg.sv ----
// Behaviour
// R1 - Refresh logic owns video memory throughout active display; processor held off.
// R2 - Processor is granted the shared bus for all of vertical blanking.
// R3 - Rows are ten scan lines; last three lines grant the processor the bus.
// R4 - Scroll reloads top-of-page; refresh addressing wraps at end of video memory.
// R5 - Address bits 12 and 13 pick one of four pages; page zero is peripherals.
// R6 - Pages one to three load top-of-page, row-start and cursor registers.
// R7 - Refresh covers 24 rows of 80 characters, 1920 positions per frame.
// R8 - Keyboard scanner drives and senses an 8 by 8 matrix of 64 keys.
// R9 - Two-key rollover: a second key pressed while first held gets its code.
// R10 - Bus-available is the OR of blanked scan-line decode and vertical blanking.
// R11 - While processor owns the bus, refresh address enable is driven low.
// R12 - Processor starts memory cycles only under bus-available, ends before removal.
package cbs_pkg;
    // Character and line geometry of the refresh timing
    localparam logic [6:0] H_ACTIVE     = 7'h50;  // 80 characters
    localparam logic [6:0] H_TOTAL      = 7'h64;  // 100 incl. retrace
    localparam logic [3:0] LINES_ROW    = 4'hA;   // 10 scan lines per row
    localparam logic [3:0] BLANK_FIRST  = 4'h7;   // lines 7..9 blanked
    localparam logic [4:0] ROWS_ACTIVE  = 5'h18;  // 24 rows
    localparam logic [4:0] ROWS_TOTAL   = 5'h1A;  // 2 rows of vertical blank

    // Page decode on address bits 13:12
    localparam int         PAGE_LSB     = 4;      // data bit carrying addr 12
    localparam logic [1:0] PAGE_PERIPH  = 2'h0;
    localparam logic [1:0] PAGE_TOP     = 2'h1;
    localparam logic [1:0] PAGE_ROWST   = 2'h2;
    localparam logic [1:0] PAGE_CURSOR  = 2'h3;

    // Reset values
    localparam logic [11:0] REG_RST     = 12'h000;
    localparam logic [7:0]  KB_DRIVE_RST = 8'hFE; // column 0 driven low
endpackage : cbs_pkg

// ---- hdl/cbs_bus_share.sv ----
`timescale 1ns/1ps
module cbs_bus_share #(
    parameter int CHAR_DIV = 8,   // clock cycles per character slot
    parameter int KB_STEP  = 16,  // clock cycles per key position
    parameter int VID_AW   = 11   // video memory address width
) (
    // Clock, reset, enable
    input  wire logic              MCLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    // Processor side
    input  wire logic              CPU_ADS,
    input  wire logic              CPU_WR,
    input  wire logic [11:0]       CPU_ADDR,
    input  wire logic [7:0]        CPU_DATA,
    output logic                   PERIPH_SEL,
    output logic                   BUS_AVAIL,
    // Refresh side
    output logic                   MEM_ADDR_EN,
    output logic [VID_AW-1:0]      REFRESH_ADDR,
    output logic                   VBLANK,
    output logic                   CURSOR_HIT,
    // Keyboard matrix
    output logic [7:0]             KB_DRIVE,
    input  wire logic [7:0]        KB_SENSE,
    output logic                   KEY_VALID,
    output logic [5:0]             KEY_CODE,
    output logic                   KEY_DOWN
);
    logic [$clog2(CHAR_DIV+1)-1:0] div_r;
    logic                          char_tick;
    logic [6:0]                    hcnt_r;
    logic [3:0]                    line_r;
    logic [4:0]                    row_r;
    logic                          line_end;
    logic                          row_end;
    logic                          vb_c;
    logic                          blank_c;
    logic [1:0]                    page_r;
    logic [11:0]                   top_r;
    logic [11:0]                   cursor_r;
    logic [VID_AW-1:0]             row_start_r;
    logic [VID_AW-1:0]             addr_c;
    logic [$clog2(KB_STEP+1)-1:0]  kstep_r;
    logic [5:0]                    kidx_r;
    logic [5:0]                    kidx_nxt;
    logic [63:0]                   held_r;
    logic                          k_sample;
    logic                          k_press;

    // Character slot strobe from the master clock
    assign char_tick = CE && (div_r == ($bits(div_r))'(CHAR_DIV - 1));
    assign line_end  = char_tick && (hcnt_r == cbs_pkg::H_TOTAL - 7'h01);
    assign row_end   = line_end && (line_r == cbs_pkg::LINES_ROW - 4'h1);
    assign vb_c      = (row_r >= cbs_pkg::ROWS_ACTIVE);
    assign blank_c   = (line_r >= cbs_pkg::BLANK_FIRST);
    assign addr_c    = row_start_r + VID_AW'(hcnt_r); // R4 natural wrap

    // Divider
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            div_r <= '0;
        end else if (CE) begin
            div_r <= char_tick ? '0 : div_r + 1'b1;
        end
    end

    // Character, scan-line and row counters
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hcnt_r <= 7'h00;
            line_r <= 4'h0;
            row_r  <= 5'h00;
        end else if (char_tick) begin
            hcnt_r <= line_end ? 7'h00 : hcnt_r + 7'h01;     // R7
            if (line_end) begin
                line_r <= row_end ? 4'h0 : line_r + 4'h1;   // R3
            end
            if (row_end) begin
                row_r <= (row_r == cbs_pkg::ROWS_TOTAL - 5'h01) ?
                         5'h00 : row_r + 5'h01;             // R7
            end
        end
    end

    // Page latch; the high address bits ride on the data bus at strobe
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            page_r <= cbs_pkg::PAGE_PERIPH;
        end else if (CE && CPU_ADS) begin
            page_r <= CPU_DATA[cbs_pkg::PAGE_LSB +: 2];     // R5
        end
    end

    // Refresh-controller registers loaded by page
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            top_r    <= cbs_pkg::REG_RST;
            cursor_r <= cbs_pkg::REG_RST;
        end else if (CE && CPU_WR) begin
            if (page_r == cbs_pkg::PAGE_TOP) begin
                top_r <= CPU_ADDR;                          // R6
            end else if (page_r == cbs_pkg::PAGE_CURSOR) begin
                cursor_r <= CPU_ADDR;                       // R6
            end
        end
    end

    // Row start: a processor load wins over the running advance, so a
    // scroll written mid-row takes effect immediately
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            row_start_r <= '0;
        end else if (CE && CPU_WR && page_r == cbs_pkg::PAGE_ROWST) begin
            row_start_r <= CPU_ADDR[VID_AW-1:0];            // R6
        end else if (row_end) begin
            if (row_r == cbs_pkg::ROWS_TOTAL - 5'h01) begin
                row_start_r <= top_r[VID_AW-1:0];           // R4
            end else if (!vb_c) begin
                row_start_r <= row_start_r + VID_AW'(cbs_pkg::H_ACTIVE); // R4
            end
        end
    end

    // Peripheral select pulse for page zero writes
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PERIPH_SEL <= 1'b0;
        end else if (CE) begin
            PERIPH_SEL <= CPU_WR && (page_r == cbs_pkg::PAGE_PERIPH); // R5
        end
    end

    // Bus share: grant is a plain OR, no arbitration state needed
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_AVAIL   <= 1'b0;
            MEM_ADDR_EN <= 1'b1;
            VBLANK      <= 1'b0;
        end else if (CE) begin
            BUS_AVAIL   <= vb_c | blank_c;                  // R10 R2 R3
            MEM_ADDR_EN <= !(vb_c | blank_c);               // R11 R1
            VBLANK      <= vb_c;
        end
    end

    // Refresh address and cursor compare
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            REFRESH_ADDR <= '0;
            CURSOR_HIT   <= 1'b0;
        end else if (CE) begin
            REFRESH_ADDR <= addr_c;                         // R1 R7
            CURSOR_HIT   <= !vb_c && (hcnt_r < cbs_pkg::H_ACTIVE) &&
                            (addr_c == cursor_r[VID_AW-1:0]);
        end
    end

    // Keyboard walk: one key position per step, column drive settles a full
    // step before its row is sampled, trading scan speed for margin
    assign k_sample = CE && (kstep_r == ($bits(kstep_r))'(KB_STEP - 1));
    assign k_press  = !KB_SENSE[kidx_r[2:0]];
    assign kidx_nxt = kidx_r + 6'h01;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            kstep_r  <= '0;
            kidx_r   <= 6'h00;
            KB_DRIVE <= cbs_pkg::KB_DRIVE_RST;
        end else if (CE) begin
            kstep_r <= k_sample ? '0 : kstep_r + 1'b1;
            if (k_sample) begin
                kidx_r   <= kidx_nxt;                       // R8
                KB_DRIVE <= ~(8'h01 << kidx_nxt[5:3]);      // R8
            end
        end
    end

    // Per-key held state gives rollover: each new closure reports once
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            held_r    <= 64'h0;
            KEY_VALID <= 1'b0;
            KEY_CODE  <= 6'h00;
            KEY_DOWN  <= 1'b0;
        end else if (CE) begin
            KEY_VALID <= 1'b0;
            KEY_DOWN  <= |held_r;
            if (k_sample) begin
                held_r[kidx_r] <= k_press;                  // R9
                if (k_press && !held_r[kidx_r]) begin
                    KEY_VALID <= 1'b1;                      // R9
                    KEY_CODE  <= kidx_r;                    // R8
                end
            end
        end
    end

    // Checks
    property p_vblank_grant;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && vb_c) |=> (BUS_AVAIL && !MEM_ADDR_EN);
    endproperty
    a_vblank_grant: assert property (p_vblank_grant) // R2
        else $error("no grant in vertical blank");

    property p_active_hold;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && !vb_c && line_r < cbs_pkg::BLANK_FIRST) |=> !BUS_AVAIL;
    endproperty
    a_active_hold: assert property (p_active_hold) // R1
        else $error("processor granted during active lines");

    property p_blank_lines;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && line_r >= 4'h7 && line_r <= 4'h9) |=> BUS_AVAIL;
    endproperty
    a_blank_lines: assert property (p_blank_lines) // R3
        else $error("no grant on blanked scan line");

    property p_or_form;
        @(posedge MCLK) disable iff (!RST_N)
        CE |=> (BUS_AVAIL == ($past(line_r) >= 4'h7 || $past(row_r) >= 5'h18));
    endproperty
    a_or_form: assert property (p_or_form) // R10
        else $error("bus available not line OR vblank");

    property p_addr_en_off;
        @(posedge MCLK) disable iff (!RST_N)
        BUS_AVAIL |-> !MEM_ADDR_EN;
    endproperty
    a_addr_en_off: assert property (p_addr_en_off) // R11
        else $error("address enable high under grant");

    property p_row_advance;
        @(posedge MCLK) disable iff (!RST_N)
        (row_end && !vb_c && row_r != 5'h19 && !CPU_WR) |=>
        row_start_r == VID_AW'($past(row_start_r) + VID_AW'(80));
    endproperty
    a_row_advance: assert property (p_row_advance) // R4
        else $error("row start did not advance by 80");

    property p_geometry;
        @(posedge MCLK) disable iff (!RST_N)
        (hcnt_r < 7'h64) && (line_r < 4'hA) && (row_r < 5'h1A);
    endproperty
    a_geometry: assert property (p_geometry) // R7
        else $error("timing counter out of range");

    property p_page_zero;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && CPU_WR && page_r == 2'h0) |=> PERIPH_SEL;
    endproperty
    a_page_zero: assert property (p_page_zero) // R5
        else $error("page zero write gave no select");

    property p_cursor_load;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && CPU_WR && page_r == 2'h3) |=> cursor_r == $past(CPU_ADDR);
    endproperty
    a_cursor_load: assert property (p_cursor_load) // R6
        else $error("cursor page did not load");

    property p_one_column;
        @(posedge MCLK) disable iff (!RST_N)
        $onehot(~KB_DRIVE);
    endproperty
    a_one_column: assert property (p_one_column) // R8
        else $error("keyboard drive not one column");

    property p_rollover;
        @(posedge MCLK) disable iff (!RST_N)
        (k_sample && k_press && !held_r[kidx_r]) |=>
        (KEY_VALID && KEY_CODE == $past(kidx_r));
    endproperty
    a_rollover: assert property (p_rollover) // R9
        else $error("new key closure not reported");
endmodule : cbs_bus_share

// ---- test/cbs_key_matrix.sv ----
`timescale 1ns/1ps
module cbs_key_matrix (
    // Scan columns from the block, active low
    input  wire logic [7:0] kb_drive,
    // Up to two held keys, index {col,row}
    input  wire logic       key_a_en,
    input  wire logic [5:0] key_a,
    input  wire logic       key_b_en,
    input  wire logic [5:0] key_b,
    // Row lines, pulled up when no switch closes
    output logic      [7:0] kb_sense
);
    // Closed switch shorts its row to a driven column
    always_comb begin
        kb_sense = 8'hFF;
        if (key_a_en && !kb_drive[key_a[5:3]]) kb_sense[key_a[2:0]] = 1'b0;
        if (key_b_en && !kb_drive[key_b[5:3]]) kb_sense[key_b[2:0]] = 1'b0;
    end
endmodule : cbs_key_matrix

// ---- test/test_crt_terminal_bus_share.sv ----
`timescale 1ns/1ps
module test_crt_terminal_bus_share;
    logic mclk, rst_n, ads, wr, ka_en, kb_en;
    logic [11:0] addr;
    logic [7:0]  data, drive, sense;
    logic [5:0]  ka, kb, code;
    logic [10:0] raddr;
    logic psel, bavail, men, vbl, chit, kvalid, kdown;
    int n_mismatch = 0;
    int n_checks = 0;
    int i, cnt;

    // Short counts keep one frame near 52000 cycles
    cbs_bus_share #(.CHAR_DIV(2), .KB_STEP(2), .VID_AW(11)) i_dut (
        .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .CPU_ADS(ads), .CPU_WR(wr),
        .CPU_ADDR(addr), .CPU_DATA(data), .PERIPH_SEL(psel),
        .BUS_AVAIL(bavail), .MEM_ADDR_EN(men), .REFRESH_ADDR(raddr),
        .VBLANK(vbl), .CURSOR_HIT(chit), .KB_DRIVE(drive), .KB_SENSE(sense),
        .KEY_VALID(kvalid), .KEY_CODE(code), .KEY_DOWN(kdown));
    cbs_key_matrix i_keys (.kb_drive(drive), .key_a_en(ka_en), .key_a(ka),
        .key_b_en(kb_en), .key_b(kb), .kb_sense(sense));

    // Free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // A bound ran out: count it and close the run
    task hang;
        n_mismatch++;
        $display("unexpected at %0t: wait ran out", $time);
        stop_test;
    endtask : hang

    // Page strobe then write; select pulse shows one cycle later
    task wr_page(input logic [1:0] pg, input logic [11:0] a);
        int w;
        // Host starts a cycle only under the grant, well before it ends
        for (w = 0; w < 2000 && bavail !== 1'b1; w++) @(negedge mclk);
        if (w == 2000) hang;
        @(negedge mclk) ads = 1'b1;
        data = {2'h0, pg, 4'h0};
        @(negedge mclk) ads = 1'b0;
        wr = 1'b1;
        addr = a;
        @(negedge mclk) wr = 1'b0;
        chk(psel, pg == 2'h0);
    endtask : wr_page

    task t_pages;
        for (i = 0; i < 4; i++) wr_page(i[1:0], 12'h000);
        wr_page(2'h1, 12'h123);
        wr_page(2'h2, 12'h7F0);
        wr_page(2'h3, 12'h005);
        // Cursor sits past the wrap of the row start
        for (i = 0; i < 2000 && chit !== 1'b1; i++) @(negedge mclk);
        if (i == 2000) hang;
        chk(raddr, 12'h005);
        $display("test pages done");
    endtask : t_pages

    // Any one active row period covers exactly three granted lines
    task t_grant;
        cnt = 0;
        for (i = 0; i < 2000; i++) begin
            @(negedge mclk);
            if (bavail === 1'b1) cnt++;
            if (men !== ~bavail) chk(men, ~bavail);
        end
        chk(12'(cnt), 12'h258);
        $display("test grant done");
    endtask : t_grant

    task t_vblank;
        for (i = 0; i < 60000 && vbl !== 1'b1; i++) @(negedge mclk);
        if (i == 60000) hang;
        for (cnt = 0; cnt < 5000 && vbl === 1'b1; cnt++) begin
            if (bavail !== 1'b1) chk(bavail, 1'b1);
            @(negedge mclk);
        end
        chk(12'(cnt), 12'hFA0);
        chk(raddr, 12'h123);
        $display("test vblank done");
    endtask : t_vblank

    task wait_key(input logic [5:0] exp);
        for (i = 0; i < 400 && kvalid !== 1'b1; i++) begin
            @(negedge mclk);
            if ((~drive & (~drive - 8'h01)) != 8'h00) chk(drive, 8'hFE);
        end
        if (i == 400) hang;
        chk(code, exp);
    endtask : wait_key

    task t_keys;
        ka = 6'h1A;
        ka_en = 1'b1;
        wait_key(6'h1A);
        @(negedge mclk) chk(kdown, 1'b1);
        kb = 6'h2D;
        kb_en = 1'b1;
        wait_key(6'h2D);
        @(negedge mclk) ka_en = 1'b0;
        kb_en = 1'b0;
        repeat (300) @(negedge mclk);
        chk(kdown, 1'b0);
        $display("test keys done");
    endtask : t_keys

    initial begin
        rst_n = 1'b0;
        {ads, wr, ka_en, kb_en} = 4'h0;
        addr = 12'h000;
        data = 8'h00;
        ka = 6'h00;
        kb = 6'h00;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_pages;
        t_grant;
        t_keys;
        t_vblank;
        stop_test;
    end
endmodule : test_crt_terminal_bus_share
